// File: design/aics_top.v
// converter input selection registers behind an axi4-lite slave
//
// Operation
// - A positive input selection register at index 0x1D1F holds a six-bit code reset to zero.
// - Positive codes 0 to 23 pick port A, B, then C pins 0 to 7 in order.
// - Positive codes 24 to 34 pick port D pins then port E pins 0 to 2, and 35 the ground-sense pin.
// - Positive codes 57 to 63 pick amplifier, analog ground, temperature, both DACs and both references.
// - Positive codes 36 to 56 connect nothing.
// - A negative input selection register at index 0x1D20 holds a six-bit code reset to zero.
// - Negative codes 57 to 63 pick amplifier, ground, temperature, DACs and reference buffers.
// - Negative port pins come only from a fixed list of low codes and all else connects nothing.
// - Port D and E selections work only on the larger package variants.
//
// Our own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "aics_regs.vh"

module aics_top (
  // clock and reset
  input  wire                   aclk,
  input  wire                   aresetn,
  // package variant strap, static
  input  wire                   large_package,
  // axi4-lite write address
  input  wire [`AICS_ADDR_W-1:0] s_axi_awaddr,
  input  wire [2:0]             s_axi_awprot,
  input  wire                   s_axi_awvalid,
  output wire                   s_axi_awready,
  // axi4-lite write data
  input  wire [31:0]            s_axi_wdata,
  input  wire [3:0]             s_axi_wstrb,
  input  wire                   s_axi_wvalid,
  output wire                   s_axi_wready,
  // axi4-lite write response
  output reg  [1:0]             s_axi_bresp,
  output reg                    s_axi_bvalid,
  input  wire                   s_axi_bready,
  // axi4-lite read address
  input  wire [`AICS_ADDR_W-1:0] s_axi_araddr,
  input  wire [2:0]             s_axi_arprot,
  input  wire                   s_axi_arvalid,
  output wire                   s_axi_arready,
  // axi4-lite read data
  output reg  [31:0]            s_axi_rdata,
  output reg  [1:0]             s_axi_rresp,
  output reg                    s_axi_rvalid,
  input  wire                   s_axi_rready,
  // analog multiplexer selections
  output wire [`AICS_SEL_W-1:0] pos_select,
  output wire [`AICS_SEL_W-1:0] neg_select,
  // live codes
  output wire [`AICS_CODE_MSB:0] positive_channel_code,
  output wire [`AICS_CODE_MSB:0] negative_channel_code
);

  // ----------------------------------------------------------------
  // register bank
  // ----------------------------------------------------------------
  reg [`AICS_CODE_MSB:0] pos_code_reg;
  reg [`AICS_CODE_MSB:0] neg_code_reg;
  reg [`AICS_SEL_W-1:0]  pos_sel_reg;
  reg [`AICS_SEL_W-1:0]  neg_sel_reg;
  reg                    aw_held_reg;
  reg                    w_held_reg;
  reg [`AICS_ADDR_W-1:0] aw_addr_reg;
  reg [31:0]             w_data_reg;
  reg [3:0]              w_strb_reg;
  wire [`AICS_SEL_W-1:0] pos_sel_next;
  wire [`AICS_SEL_W-1:0] neg_sel_next;
  wire                   do_write;
  wire                   do_read;
  wire                   aw_take;
  wire                   w_take;
  wire [1:0]             wr_hit;
  wire [1:0]             rd_hit;
  wire                   code_lane;
  wire                   pos_wr_en;
  wire                   neg_wr_en;
  reg                    strap_meta_reg;
  reg                    strap_sync_reg;
  reg [1:0]              bresp_next;
  reg [31:0]             rdata_next;
  reg [1:0]              rresp_next;

  // ----------------------------------------------------------------
  // package strap synchroniser
  // ----------------------------------------------------------------
  // the strap is a pin, so it crosses two flops before the decoders use it;
  // it is meant to be static, so a change is only trusted across a reset
  always @(posedge aclk) begin
    strap_meta_reg <= large_package;
    strap_sync_reg <= strap_meta_reg;
  end

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  function [1:0] reg_hit;
    input [`AICS_ADDR_W-1:0] a;
    begin
      if (a == {`AICS_POS_SEL_IDX, 2'b00}) begin
        reg_hit = 2'b01;
      end else if (a == {`AICS_NEG_SEL_IDX, 2'b00}) begin
        reg_hit = 2'b10;
      end else begin
        reg_hit = 2'b00;
      end
    end
  endfunction

  // read value of a code register; the unused upper bits are tied low
  function [31:0] code_word;
    input [`AICS_CODE_MSB:0] c;
    begin
      code_word = {{(32-`AICS_CODE_W){1'b0}}, c};
    end
  endfunction

  // ----------------------------------------------------------------
  // handshakes and write enables
  // ----------------------------------------------------------------
  // address and data held until both are present, then answered
  assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
  assign s_axi_wready  = !w_held_reg && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign do_write      = aw_held_reg && w_held_reg && !s_axi_bvalid;
  assign aw_take       = s_axi_awvalid && s_axi_awready;
  assign w_take        = s_axi_wvalid && s_axi_wready;
  assign do_read       = s_axi_arvalid && s_axi_arready;
  assign wr_hit        = reg_hit(aw_addr_reg);
  assign rd_hit        = reg_hit(s_axi_araddr);
  // only the low byte lane carries code bits
  assign code_lane     = w_strb_reg[0];
  assign pos_wr_en     = do_write && code_lane && (wr_hit == 2'b01);
  assign neg_wr_en     = do_write && code_lane && (wr_hit == 2'b10);

  // ----------------------------------------------------------------
  // write address and data capture
  // ----------------------------------------------------------------
  // a take and a release never meet: ready is low while a beat is held
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= {`AICS_ADDR_W{1'b0}};
    end else if (aw_take) begin
      aw_held_reg <= 1'b1;
      aw_addr_reg <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held_reg <= 1'b0;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      w_held_reg <= 1'b0;
      w_data_reg <= 32'h00000000;
      w_strb_reg <= 4'h0;
    end else if (w_take) begin
      w_held_reg <= 1'b1;
      w_data_reg <= s_axi_wdata;
      w_strb_reg <= s_axi_wstrb;
    end else if (do_write) begin
      w_held_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // write response
  // ----------------------------------------------------------------
  always @* begin
    bresp_next = `AICS_RESP_OKAY;
    if (wr_hit == 2'b00) begin
      bresp_next = `AICS_RESP_SLVERR;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `AICS_RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= bresp_next;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // code registers
  // ----------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      pos_code_reg <= `AICS_CODE_RST;
      neg_code_reg <= `AICS_CODE_RST;
    end else begin
      // upper data bits are never stored, so they cannot be set
      if (pos_wr_en) begin
        pos_code_reg <= w_data_reg[`AICS_CODE_MSB:0];
      end
      if (neg_wr_en) begin
        neg_code_reg <= w_data_reg[`AICS_CODE_MSB:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // read channel
  // ----------------------------------------------------------------
  // unmapped reads answer zero with an error, mapped ones never fail
  always @* begin
    rdata_next = 32'h00000000;
    rresp_next = `AICS_RESP_OKAY;
    case (rd_hit)
      2'b01:   rdata_next = code_word(pos_code_reg);
      2'b10:   rdata_next = code_word(neg_code_reg);
      default: rresp_next = `AICS_RESP_SLVERR;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `AICS_RESP_OKAY;
    end else if (do_read) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rdata_next;
      s_axi_rresp  <= rresp_next;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // selection decode, registered so the mux sees clean switching
  // ----------------------------------------------------------------
  aics_decode #(
    .NEGATIVE (0)
  ) u_pos_decode (
    .code          (pos_code_reg),
    .large_package (strap_sync_reg),
    .sel           (pos_sel_next)
  );

  aics_decode #(
    .NEGATIVE (1)
  ) u_neg_decode (
    .code          (neg_code_reg),
    .large_package (strap_sync_reg),
    .sel           (neg_sel_next)
  );

  always @(posedge aclk) begin
    if (!aresetn) begin
      pos_sel_reg <= {`AICS_SEL_W{1'b0}};
      neg_sel_reg <= {`AICS_SEL_W{1'b0}};
    end else begin
      pos_sel_reg <= pos_sel_next;
      neg_sel_reg <= neg_sel_next;
    end
  end

  assign pos_select            = pos_sel_reg;
  assign neg_select            = neg_sel_reg;
  assign positive_channel_code = pos_code_reg;
  assign negative_channel_code = neg_code_reg;

endmodule
`default_nettype wire

// File: design/aics_regs.vh
// register offsets, field layout and reset values of the converter input selection bank
`ifndef AICS_REGS_VH
`define AICS_REGS_VH

// ----------------------------------------------------------------
// register offsets, printed offsets are word indices
// ----------------------------------------------------------------
`define AICS_POS_SEL_IDX   16'h1D1F
`define AICS_NEG_SEL_IDX   16'h1D20
`define AICS_ADDR_W        18

// ----------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------
`define AICS_CODE_W        6
`define AICS_CODE_MSB      5
`define AICS_CODE_RST      6'h00

// ----------------------------------------------------------------
// selection vector layout
// ----------------------------------------------------------------
`define AICS_SEL_W         43
`define AICS_SEL_PORTA     0
`define AICS_SEL_PORTB     8
`define AICS_SEL_PORTC     16
`define AICS_SEL_PORTD     24
`define AICS_SEL_PORTE     32
`define AICS_SEL_GND_SENSE 35
`define AICS_SEL_AMP       36
`define AICS_SEL_AGND      37
`define AICS_SEL_TEMP      38
`define AICS_SEL_DAC1      39
`define AICS_SEL_DAC2      40
`define AICS_SEL_REF1      41
`define AICS_SEL_REF2      42

// ----------------------------------------------------------------
// axi responses
// ----------------------------------------------------------------
`define AICS_RESP_OKAY     2'h0
`define AICS_RESP_SLVERR   2'h2

`endif

// File: design/aics_decode.v
// one-hot decoder from a six-bit channel code to the analog multiplexer selection
`timescale 1ns/1ps
`default_nettype none
`include "aics_regs.vh"

module aics_decode #(
  parameter NEGATIVE = 0
) (
  // code and variant
  input  wire [`AICS_CODE_MSB:0] code,
  input  wire                    large_package,
  // selection
  output reg  [`AICS_SEL_W-1:0]  sel
);

  // ----------------------------------------------------------------
  // negative side port pin whitelist
  // ----------------------------------------------------------------
  function neg_pin_ok;
    input [5:0] c;
    begin
      case (c)
        6'h01, 6'h03, 6'h05, 6'h06, 6'h08, 6'h0A, 6'h0C, 6'h0E, 6'h11, 6'h13, 6'h16,
        6'h1A, 6'h1B, 6'h1D, 6'h1F, 6'h21: neg_pin_ok = 1'b1;
        default: neg_pin_ok = 1'b0;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  always @* begin
    sel = {`AICS_SEL_W{1'b0}};
    if (code <= 6'h22) begin
      // port pins map linearly onto the vector
      if ((NEGATIVE == 0) || neg_pin_ok(code)) begin
        // port d and e pins only exist on the larger package
        if ((code < 6'h18) || large_package) begin
          sel[code] = 1'b1;
        end
      end
    end else begin
      case (code)
        6'h23: begin
          if (NEGATIVE == 0) begin
            sel[`AICS_SEL_GND_SENSE] = 1'b1;
          end
        end
        6'h39: sel[`AICS_SEL_AMP]  = 1'b1;
        6'h3A: sel[`AICS_SEL_AGND] = 1'b1;
        6'h3B: sel[`AICS_SEL_TEMP] = 1'b1;
        6'h3C: sel[`AICS_SEL_DAC1] = 1'b1;
        6'h3D: sel[`AICS_SEL_DAC2] = 1'b1;
        6'h3E: sel[`AICS_SEL_REF1] = 1'b1;
        6'h3F: sel[`AICS_SEL_REF2] = 1'b1;
        // reserved codes leave the input floating
        default: sel = {`AICS_SEL_W{1'b0}};
      endcase
    end
  end

endmodule
`default_nettype wire

// File: test/aics_sva.sv
// assertions on the ports of the converter input selection bank
`timescale 1ns/1ps
`default_nettype none
module aics_sva (
  // clock, reset, strap
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        large_package,
  // bus responses
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // selections and codes
  input wire logic [42:0] pos_select,
  input wire logic [42:0] neg_select,
  input wire logic [5:0]  positive_channel_code,
  input wire logic [5:0]  negative_channel_code
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_bresp_held: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  a_upper_bits_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:6] == 26'h0)
    else $error("upper read bits not zero");
  a_code_needs_write: assert property (!$rose(s_axi_bvalid) |->
    $stable(positive_channel_code) && $stable(negative_channel_code))
    else $error("code changed without a write");
  // sampled reset in the antecedents keeps the release edge from starting an attempt
  a_pos_pin_sel: assert property (aresetn && positive_channel_code < 36 &&
    (large_package || positive_channel_code < 24 || positive_channel_code > 34)
    |=> pos_select == (43'h1 << $past(positive_channel_code)))
    else $error("positive pin selection wrong");
  a_pos_internal: assert property (aresetn && positive_channel_code >= 57
    |=> pos_select == (43'h1 << ($past(positive_channel_code) - 6'd21)))
    else $error("positive internal selection wrong");
  a_pos_reserved: assert property (aresetn && positive_channel_code inside {[36:56]}
    |=> pos_select == 43'h0)
    else $error("positive reserved code connects");
  a_small_package: assert property (aresetn && !large_package &&
    positive_channel_code inside {[24:34]} |=> pos_select == 43'h0)
    else $error("port d or e selected on small package");
  a_neg_internal: assert property (aresetn && negative_channel_code >= 57
    |=> neg_select == (43'h1 << ($past(negative_channel_code) - 6'd21)))
    else $error("negative internal selection wrong");
  a_neg_reserved: assert property (aresetn && negative_channel_code inside {[34:56]}
    |=> neg_select == 43'h0)
    else $error("negative reserved code connects");
endmodule
bind aics_top aics_sva i_sva (.aclk, .aresetn, .large_package, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .pos_select, .neg_select,
  .positive_channel_code, .negative_channel_code);
`default_nettype wire

// File: test/tb_top.sv
// self-checking bench for the converter input selection bank
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic aclk, aresetn, large_package, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [17:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [42:0] pos_select, neg_select;
  logic [5:0]  positive_channel_code, negative_channel_code;
  int          mismatches = 0, checks = 0, cyc = 0;
  // printed offsets are word indices, so byte address is four times larger
  localparam logic [17:0] POS_A = 18'h0747C, NEG_A = 18'h07480, BAD_A = 18'h07484;
  aics_top i_dut (.aclk, .aresetn, .large_package, .s_axi_awaddr, .s_axi_awprot(3'h0),
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0),
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .pos_select, .neg_select, .positive_channel_code, .negative_channel_code);
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    if (mismatches == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic cmp_w(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic cmp_s(input logic [42:0] g, input logic [42:0] e);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  // one-hot selection expected for a code; masks list the codes that connect anything
  function automatic logic [42:0] exp_sel(input logic neg, input logic [5:0] c, input logic lg);
    logic [63:0] m;
    logic [42:0] e;
    m = neg ? 64'hFE00_0002_AC4A_556A : 64'hFE00_000F_FFFF_FFFF;
    e = 43'h0;
    if (m[c] && (lg || c < 24 || c > 34)) e[c < 36 ? c : c - 6'd21] = 1'b1;
    return e;
  endfunction
  task automatic wr(input logic [17:0] a, input logic [31:0] d, input logic [3:0] s,
                    output logic [1:0] r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rd(input logic [17:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic t_reset(input logic lg);
    logic [31:0] d;
    logic [1:0]  r;
    aresetn <= 1'b0;
    large_package <= lg;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    cmp_s(pos_select, exp_sel(1'b0, 6'h00, lg));
    cmp_s(neg_select, 43'h0);
    cmp_w({26'h0, positive_channel_code}, 32'h0);
    cmp_w({26'h0, negative_channel_code}, 32'h0);
    rd(POS_A, d, r);
    cmp_w(d, 32'h0);
    rd(NEG_A, d, r);
    cmp_w(d, 32'h0);
  endtask
  // every code on both inputs, with the upper write bits set
  task automatic t_sweep(input logic lg);
    logic [31:0] d;
    logic [1:0]  r;
    for (int c = 0; c < 64; c++) begin
      wr(POS_A, {26'h3FFFFFF, c[5:0]}, 4'hF, r);
      cmp_w({30'h0, r}, 32'h0);
      wr(NEG_A, {26'h3FFFFFF, c[5:0] ^ 6'h2A}, 4'hF, r);
      cmp_w({30'h0, r}, 32'h0);
      cmp_w({26'h0, positive_channel_code}, {26'h0, c[5:0]});
      cmp_w({26'h0, negative_channel_code}, {26'h0, c[5:0] ^ 6'h2A});
      rd(POS_A, d, r);
      cmp_w(d, {26'h0, c[5:0]});
      rd(NEG_A, d, r);
      cmp_w(d, {26'h0, c[5:0] ^ 6'h2A});
      cmp_s(pos_select, exp_sel(1'b0, c[5:0], lg));
      cmp_s(neg_select, exp_sel(1'b1, c[5:0] ^ 6'h2A, lg));
    end
  endtask
  task automatic t_refuse();
    logic [31:0] d;
    logic [1:0]  r;
    wr(POS_A, 32'h15, 4'hF, r);
    wr(POS_A, 32'h2A, 4'h0, r);
    cmp_w({30'h0, r}, 32'h0);
    cmp_w({26'h0, positive_channel_code}, 32'h15);
    wr(BAD_A, 32'h3F, 4'hF, r);
    cmp_w({30'h0, r}, 32'h2);
    rd(BAD_A, d, r);
    cmp_w({d[29:0], r}, 32'h2);
    rd(POS_A, d, r);
    cmp_w(d, 32'h15);
  endtask
  initial begin
    {aresetn, large_package, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 5'h0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 38'h0;
    {s_axi_wdata, s_axi_wstrb} = 36'h0;
    @(posedge aclk);
    for (int lg = 0; lg < 2; lg++) begin
      t_reset(lg[0]);
      t_sweep(lg[0]);
      t_refuse();
    end
    wrap_up();
  end
endmodule
`default_nettype wire
